/* File: dv/dpsl_mcu_model.sv */
// Serial bus master model of the controlling microcontroller
`timescale 1ns/10ps
`default_nettype none
module dpsl_mcu_model (
	input  wire logic clock,
	input  wire logic sdo,
	input  wire logic sdo_oe,
	output logic      cs_n,
	output logic      sclk,
	output logic      sdi
);
	logic line;

	// Released data line reads as the inverse of the last driven level
	assign line = sdo_oe ? sdo : !sdo;

	initial
	begin
		cs_n = 1'b1;
		sclk = 1'b0;
		sdi  = 1'b0;
	end

	task automatic idle(input int n);
		repeat (n) @(negedge clock);
	endtask : idle

	// Word LSB first; fewer than 16 bits aborts the frame
	task automatic xfer(input logic [15:0] w, input int nb, output logic [15:0] rx);
		rx = 16'h0000;
		cs_n = 1'b0;
		idle(6);
		rx[0] = line;
		for (int i = 0; i < nb; i++)
		begin
			sdi = w[i];
			idle(4);
			rx[i] = line;
			sclk = 1'b1;
			idle(4);
			sclk = 1'b0;
		end
		idle(4);
		cs_n = 1'b1;
		idle(8);
	endtask : xfer
endmodule : dpsl_mcu_model
`default_nettype wire

/* File: dv/dpsl_top_test.sv */
// Self-checking bench for the protection and status logic
`timescale 1ns/10ps
`default_nettype none
module dpsl_top_test;
	import dpsl_pkg::*;
	typedef struct {logic [15:0] cmd; logic [11:0] oe; logic sb;} dpsl_row_t;
	logic        clock, resetn, cs_n, sclk, sdi, osc_clk, hw_inhibit_pin, undervoltage;
	logic        temp_above_prewarn, temp_below_prewarn, temp_above_shutdown;
	logic        temp_below_switch_on, sdo, sdo_oe, temp_prewarn_flag, short_detected_flag;
	logic        supply_fail_flag, thermal_shutdown, standby, prev_sb;
	logic [11:0] overcurrent, out_enable, prev_oe;
	logic [15:0] rx;
	int          errors      = 0;
	int          checks_done = 0;
	dpsl_row_t   rows [4]    = '{'{16'h8002, 12'h001, 1'b0}, '{16'hdffe, 12'hfff, 1'b0},
		'{16'h5ffe, 12'h000, 1'b1}, '{16'h8aaa, 12'h555, 1'b0}};

	dpsl_top #(.OSC_FREQ_HZ(4000)) DUT (
		.clock                (clock),
		.resetn               (resetn),
		.cs_n                 (cs_n),
		.sclk                 (sclk),
		.sdi                  (sdi),
		.osc_clk              (osc_clk),
		.hw_inhibit_pin       (hw_inhibit_pin),
		.temp_above_prewarn   (temp_above_prewarn),
		.temp_below_prewarn   (temp_below_prewarn),
		.temp_above_shutdown  (temp_above_shutdown),
		.temp_below_switch_on (temp_below_switch_on),
		.undervoltage         (undervoltage),
		.overcurrent          (overcurrent),
		.sdo                  (sdo),
		.sdo_oe               (sdo_oe),
		.out_enable           (out_enable),
		.temp_prewarn_flag    (temp_prewarn_flag),
		.short_detected_flag  (short_detected_flag),
		.supply_fail_flag     (supply_fail_flag),
		.thermal_shutdown     (thermal_shutdown),
		.standby              (standby)
	);
	dpsl_mcu_model mc (
		.clock  (clock),
		.sdo    (sdo),
		.sdo_oe (sdo_oe),
		.cs_n   (cs_n),
		.sclk   (sclk),
		.sdi    (sdi)
	);

	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
		checks_done++;
		if (s !== e)
		begin
			errors++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	task automatic end_of_test();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_of_test

	initial
	begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	// Free-running timer oscillator, 400 ns per tick
	initial
	begin
		osc_clk = 1'b0;
		forever #200 osc_clk = ~osc_clk;
	end

	initial
	begin
		#400000;
		errors++;
		end_of_test();
	end

	initial
	begin
		resetn = 1'b0;
		hw_inhibit_pin = 1'b1;
		undervoltage = 1'b0;
		temp_above_prewarn = 1'b0;
		temp_below_prewarn = 1'b1;
		temp_above_shutdown = 1'b0;
		temp_below_switch_on = 1'b1;
		overcurrent = 12'h000;
		mc.idle(2);
		chk("reset standby", 16'h1, 16'(standby));
		chk("reset out_enable", 16'h0, 16'(out_enable));
		chk("reset sdo_oe", 16'h0, 16'(sdo_oe));
		resetn = 1'b1;
		mc.idle(6);
		prev_oe = 12'h000;
		prev_sb = 1'b0;
		foreach (rows[i])
		begin
			mc.xfer(rows[i].cmd, 16, rx);
			chk("out_enable", 16'(rows[i].oe), 16'(out_enable));
			chk("standby", 16'(rows[i].sb), 16'(standby));
			chk("status outputs", 16'(prev_oe), 16'(rx[12:1]));
			chk("status inhibit", 16'(prev_sb), 16'(rx[14]));
			prev_oe = rows[i].oe;
			prev_sb = rows[i].sb;
		end
		// Pin inhibit, link keeps working
		mc.xfer(16'hdffe, 16, rx);
		hw_inhibit_pin = 1'b0;
		mc.idle(6);
		chk("pin inhibit oe", 16'h0, 16'(out_enable));
		chk("pin standby", 16'h1, 16'(standby));
		mc.xfer(16'h5ffe, 16, rx);
		chk("standby status", 16'h4000, rx & 16'h5ffe);
		hw_inhibit_pin = 1'b1;
		mc.idle(6);
		chk("soft inhibit oe", 16'h0, 16'(out_enable));
		mc.xfer(16'hdffe, 16, rx);
		chk("release oe", 16'hfff, 16'(out_enable));
		// Prewarning peek and aborted frames
		temp_above_prewarn = 1'b1;
		temp_below_prewarn = 1'b0;
		mc.idle(6);
		chk("prewarn set", 16'h1, 16'(temp_prewarn_flag));
		mc.xfer(16'h0000, 0, rx);
		chk("peek sdo", 16'h1, 16'(rx[0]));
		chk("peek oe released", 16'h0, 16'(sdo_oe));
		mc.xfer(16'h0000, 8, rx);
		chk("abort oe", 16'hfff, 16'(out_enable));
		chk("abort standby", 16'h0, 16'(standby));
		overcurrent = 12'hffc;
		mc.idle(6);
		chk("hot short oe", 16'h003, 16'(out_enable));
		chk("hot short flag", 16'h1, 16'(short_detected_flag));
		overcurrent = 12'h000;
		temp_above_prewarn = 1'b0;
		temp_below_prewarn = 1'b1;
		mc.idle(6);
		chk("prewarn clear", 16'h0, 16'(temp_prewarn_flag));
		mc.xfer(16'hdfff, 16, rx);
		chk("clear oe", 16'hfff, 16'(out_enable));
		chk("clear flag", 16'h0, 16'(short_detected_flag));
		// Short delay of 6 ticks, restart after a gap
		mc.xfer(16'h9ffe, 16, rx);
		overcurrent[0] = 1'b1;
		mc.idle(64);
		overcurrent[0] = 1'b0;
		mc.idle(32);
		overcurrent[0] = 1'b1;
		mc.idle(64);
		chk("restart oe", 16'h1, 16'(out_enable[0]));
		mc.idle(48);
		chk("short trip oe", 16'h0, 16'(out_enable[0]));
		chk("short trip flag", 16'h1, 16'(short_detected_flag));
		overcurrent[0] = 1'b0;
		// Long delay of 48 ticks
		mc.xfer(16'hfffe, 16, rx);
		overcurrent[1] = 1'b1;
		mc.idle(704);
		chk("long early oe", 16'h1, 16'(out_enable[1]));
		mc.idle(128);
		chk("long trip oe", 16'h0, 16'(out_enable[1]));
		overcurrent[1] = 1'b0;
		mc.xfer(16'hffff, 16, rx);
		chk("reenable oe", 16'hfff, 16'(out_enable));
		// Supply fail: outputs off while low, flag sticky until status reset
		undervoltage = 1'b1;
		mc.idle(6);
		chk("uv oe", 16'h0, 16'(out_enable));
		chk("uv flag", 16'h1, 16'(supply_fail_flag));
		undervoltage = 1'b0;
		mc.idle(6);
		chk("uv back oe", 16'hfff, 16'(out_enable));
		chk("uv flag held", 16'h1, 16'(supply_fail_flag));
		mc.xfer(16'hffff, 16, rx);
		chk("uv status", 16'h1, 16'(rx[15]));
		chk("uv flag clear", 16'h0, 16'(supply_fail_flag));
		// Thermal shutdown and restart
		temp_above_shutdown = 1'b1;
		temp_below_switch_on = 1'b0;
		mc.idle(6);
		chk("shutdown oe", 16'h0, 16'(out_enable));
		chk("shutdown flag", 16'h1, 16'(thermal_shutdown));
		temp_above_shutdown = 1'b0;
		mc.xfer(16'hffff, 16, rx);
		chk("shutdown status", 16'hffff, rx);
		chk("hot reset oe", 16'h0, 16'(out_enable));
		temp_below_switch_on = 1'b1;
		mc.xfer(16'hffff, 16, rx);
		chk("cool reset oe", 16'hfff, 16'(out_enable));
		// Reset in mid-run, then the link must work again
		resetn = 1'b0;
		mc.idle(2);
		chk("mid reset oe", 16'h0, 16'(out_enable));
		chk("mid reset standby", 16'h1, 16'(standby));
		resetn = 1'b1;
		mc.idle(6);
		chk("mid release standby", 16'h0, 16'(standby));
		mc.xfer(16'h8002, 16, rx);
		chk("mid release oe", 16'h001, 16'(out_enable));
		chk("mid release status", 16'h0000, rx);
		end_of_test();
	end
endmodule : dpsl_top_test
`default_nettype wire

/* File: pkg/dpsl_pkg.sv */
// Constants shared by the driver protection and status logic
package dpsl_pkg;

	localparam int          DPSL_WORD_W       = 16;
	localparam int          DPSL_NUM_OUT      = 12;
	localparam int          DPSL_CNT_W        = 5;
	localparam logic [4:0]  DPSL_FULL_BITS    = 5'h10;
	localparam int          DPSL_SYNC_W       = 22;
	localparam int          DPSL_OSC_FREQ_HZ  = 32000;
	localparam int          DPSL_LONG_DLY_US  = 12000;
	localparam int          DPSL_SHORT_DLY_US = 1500;
	localparam int          DPSL_TMR_W        = 16;

	// Command word fields
	localparam int          DPSL_CMD_SRR      = 0;
	localparam int          DPSL_CMD_OUT_LO   = 1;
	localparam int          DPSL_CMD_OUT_HI   = 12;
	localparam int          DPSL_CMD_OLD      = 13;
	localparam int          DPSL_CMD_SCT      = 14;
	localparam int          DPSL_CMD_SI       = 15;
	localparam logic [15:0] DPSL_CMD_RST      = 16'he000;

	// Status word fields
	localparam int          DPSL_ST_TP        = 0;
	localparam int          DPSL_ST_SCD       = 13;
	localparam int          DPSL_ST_INH       = 14;
	localparam int          DPSL_ST_PSF       = 15;
	localparam logic [15:0] DPSL_ST_SHUTDOWN  = 16'hffff;

	// Synchroniser lane positions
	localparam int          DPSL_SY_CSN       = 0;
	localparam int          DPSL_SY_SCLK      = 1;
	localparam int          DPSL_SY_SDI       = 2;
	localparam int          DPSL_SY_OSC       = 3;
	localparam int          DPSL_SY_INH       = 4;
	localparam int          DPSL_SY_PWSET     = 5;
	localparam int          DPSL_SY_PWRST     = 6;
	localparam int          DPSL_SY_SDOFF     = 7;
	localparam int          DPSL_SY_SDON      = 8;
	localparam int          DPSL_SY_UV        = 9;
	localparam int          DPSL_SY_OC        = 10;
	localparam logic [21:0] DPSL_SYNC_RST     = 22'h000001;

	typedef enum {DPSL_IDLE, DPSL_SHIFT} dpsl_link_t;

	// Oscillator cycles for a delay in microseconds, rounded up, at least one
	function automatic logic [15:0] dpsl_osc_cycles(input int us, input int freq_hz);
		longint c;
		c = (longint'(us) * longint'(freq_hz) + 64'd999999) / 64'd1000000;
		if (c < 1)
			c = 1;
		return c[15:0];
	endfunction : dpsl_osc_cycles

endpackage : dpsl_pkg

/* File: src/dpsl_short_timer.sv */
// Short-circuit delay timer and trip latch for one output
`timescale 1ns/10ps
`default_nettype none
module dpsl_short_timer import dpsl_pkg::*; #(
	parameter logic [15:0] LONG_CNT  = 16'h0180,
	parameter logic [15:0] SHORT_CNT = 16'h0030
) (
	input  wire logic clock,
	input  wire logic resetn,
	input  wire logic osc_tick,
	input  wire logic overcurrent,
	input  wire logic prewarn,
	input  wire logic long_sel,
	input  wire logic clear,
	output logic      trip_evt,
	output logic      tripped_r
);

	logic [15:0] cnt_r;
	logic [15:0] limit;

	assign limit    = long_sel ? LONG_CNT : SHORT_CNT;
	assign trip_evt = overcurrent && !tripped_r &&
		(prewarn || (osc_tick && cnt_r + 16'h0001 >= limit));

	// Counts oscillator cycles while the overload lasts
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			cnt_r <= 16'h0000;
		else if (!overcurrent || tripped_r)
			cnt_r <= 16'h0000;
		else if (osc_tick)
			cnt_r <= cnt_r + 16'h0001;
	end

	// Trip wins over a clear in the same cycle
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			tripped_r <= 1'b0;
		else if (trip_evt)
			tripped_r <= 1'b1;
		else if (clear)
			tripped_r <= 1'b0;
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);

	a_prewarn_trip: assert property (
		(overcurrent && prewarn && !tripped_r) |=> tripped_r)
		else $error("overload under prewarning did not trip at once");

	a_no_early_trip: assert property (
		(!tripped_r && !prewarn && (!osc_tick || cnt_r + 16'h0001 < limit)) |=> !tripped_r)
		else $error("output tripped before its delay");

endmodule : dpsl_short_timer
`default_nettype wire

/* File: src/dpsl_sync.sv */
// Two-flop synchroniser for a vector of asynchronous levels
`timescale 1ns/10ps
`default_nettype none
module dpsl_sync #(
	parameter int             WIDTH   = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input  wire logic             clock,
	input  wire logic             resetn,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_r;

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			meta_r   <= RST_VAL;
			sync_out <= RST_VAL;
		end
		else
		begin
			meta_r   <= async_in;
			sync_out <= meta_r;
		end
	end

endmodule : dpsl_sync
`default_nettype wire

/* File: src/dpsl_top.sv */
// Protection, status and serial word logic of a twelve-output load driver
// Operation
// - Prewarning flag follows set and reset thresholds
// - Chip select fall puts prewarning on output
// - Short frame aborts, registers stay unchanged
// - Overtemperature shuts outputs, status all ones
// - Re-enable needs cool die and status reset
// - Overcurrent starts the short delay timer
// - Persistent overcurrent disables output, sets flag
// - Prewarning plus overcurrent disables output at once
// - Status reset clears flag, re-enables shorted outputs
// - Either inhibit turns outputs off, link runs
// - Inhibit released reactivates the output stages
// - Timer bit selects 12 ms or 1.5 ms
// - Status bit 14 reports combined inhibit
// - Command bit 15 is the software inhibit
`timescale 1ns/10ps
`default_nettype none
module dpsl_top import dpsl_pkg::*; #(
	parameter int OSC_FREQ_HZ = DPSL_OSC_FREQ_HZ
) (
	input  wire logic        clock,
	input  wire logic        resetn,
	input  wire logic        cs_n,
	input  wire logic        sclk,
	input  wire logic        sdi,
	input  wire logic        osc_clk,
	input  wire logic        hw_inhibit_pin,
	input  wire logic        temp_above_prewarn,
	input  wire logic        temp_below_prewarn,
	input  wire logic        temp_above_shutdown,
	input  wire logic        temp_below_switch_on,
	input  wire logic        undervoltage,
	input  wire logic [11:0] overcurrent,
	output logic             sdo,
	output logic             sdo_oe,
	output logic      [11:0] out_enable,
	output logic             temp_prewarn_flag,
	output logic             short_detected_flag,
	output logic             supply_fail_flag,
	output logic             thermal_shutdown,
	output logic             standby
);

	localparam logic [15:0] LONG_CNT  = dpsl_osc_cycles(DPSL_LONG_DLY_US, OSC_FREQ_HZ);
	localparam logic [15:0] SHORT_CNT = dpsl_osc_cycles(DPSL_SHORT_DLY_US, OSC_FREQ_HZ);

	logic [DPSL_SYNC_W-1:0] sy;
	logic                   cs_s;
	logic                   sclk_s;
	logic                   osc_s;
	logic                   inh_s;
	logic                   pw_set_s;
	logic                   pw_rst_s;
	logic                   sd_off_s;
	logic                   sd_on_s;
	logic                   uv_s;
	logic [11:0]            oc_s;
	logic                   cs_prev_r;
	logic                   sclk_prev_r;
	logic                   osc_prev_r;
	logic                   cs_fall;
	logic                   cs_rise;
	logic                   sclk_rise;
	logic                   sclk_fall;
	logic                   osc_tick;
	dpsl_link_t             link_r;
	logic [4:0]             bit_cnt_r;
	logic [15:0]            in_shift_r;
	logic [15:0]            out_shift_r;
	logic [15:0]            cmd_r;
	logic                   srr_pulse_r;
	logic                   word_ok;
	logic                   tp_r;
	logic                   tsd_r;
	logic                   scd_r;
	logic                   psf_r;
	logic [11:0]            tripped;
	logic [11:0]            trip_evt;
	logic                   inhibit;
	logic [11:0]            out_en_nxt;
	logic [15:0]            status_word;

	dpsl_sync #(
		.WIDTH   (DPSL_SYNC_W),
		.RST_VAL (DPSL_SYNC_RST)
	) u_sync (
		.clock    (clock),
		.resetn   (resetn),
		.async_in ({overcurrent, undervoltage, temp_below_switch_on, temp_above_shutdown,
			temp_below_prewarn, temp_above_prewarn, hw_inhibit_pin, osc_clk, sdi, sclk, cs_n}),
		.sync_out (sy)
	);

	assign cs_s     = sy[DPSL_SY_CSN];
	assign sclk_s   = sy[DPSL_SY_SCLK];
	assign osc_s    = sy[DPSL_SY_OSC];
	assign inh_s    = sy[DPSL_SY_INH];
	assign pw_set_s = sy[DPSL_SY_PWSET];
	assign pw_rst_s = sy[DPSL_SY_PWRST];
	assign sd_off_s = sy[DPSL_SY_SDOFF];
	assign sd_on_s  = sy[DPSL_SY_SDON];
	assign uv_s     = sy[DPSL_SY_UV];
	assign oc_s     = sy[DPSL_SY_OC +: DPSL_NUM_OUT];

	// Edge detection on synchronised levels
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			cs_prev_r   <= 1'b1;
			sclk_prev_r <= 1'b0;
			osc_prev_r  <= 1'b0;
		end
		else
		begin
			cs_prev_r   <= cs_s;
			sclk_prev_r <= sclk_s;
			osc_prev_r  <= osc_s;
		end
	end

	assign cs_fall   = cs_prev_r && !cs_s;
	assign cs_rise   = !cs_prev_r && cs_s;
	assign sclk_rise = !sclk_prev_r && sclk_s;
	assign sclk_fall = sclk_prev_r && !sclk_s;
	assign osc_tick  = !osc_prev_r && osc_s;
	assign word_ok   = (bit_cnt_r == DPSL_FULL_BITS);

	// Serial frame: LSB first, sample on rising, shift out on falling
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			link_r      <= DPSL_IDLE;
			bit_cnt_r   <= 5'h00;
			in_shift_r  <= 16'h0000;
			out_shift_r <= 16'h0000;
			sdo         <= 1'b0;
			sdo_oe      <= 1'b0;
		end
		else
		begin
			case (link_r)
				DPSL_IDLE:
				begin
					if (cs_fall)
					begin
						link_r      <= DPSL_SHIFT;
						bit_cnt_r   <= 5'h00;
						out_shift_r <= status_word;
						sdo         <= status_word[DPSL_ST_TP];
						sdo_oe      <= 1'b1;
					end
				end
				DPSL_SHIFT:
				begin
					if (cs_rise)
					begin
						link_r <= DPSL_IDLE;
						sdo_oe <= 1'b0;
					end
					else
					begin
						if (sclk_rise)
						begin
							in_shift_r <= {sy[DPSL_SY_SDI], in_shift_r[15:1]};
							if (bit_cnt_r != 5'h1f)
								bit_cnt_r <= bit_cnt_r + 5'h01;
						end
						if (sclk_fall)
						begin
							out_shift_r <= {in_shift_r[0], out_shift_r[15:1]};
							sdo         <= out_shift_r[1];
						end
					end
				end
				default:
					link_r <= DPSL_IDLE;
			endcase
		end
	end

	// Command word latched only on a complete frame
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			cmd_r       <= DPSL_CMD_RST;
			srr_pulse_r <= 1'b0;
		end
		else if (link_r == DPSL_SHIFT && cs_rise && word_ok)
		begin
			cmd_r                <= in_shift_r;
			cmd_r[DPSL_CMD_SRR]  <= 1'b0;
			srr_pulse_r          <= in_shift_r[DPSL_CMD_SRR];
		end
		else
			srr_pulse_r <= 1'b0;
	end

	// Prewarning with hysteresis from two comparators
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			tp_r <= 1'b0;
		else if (pw_set_s)
			tp_r <= 1'b1;
		else if (pw_rst_s)
			tp_r <= 1'b0;
	end

	// Thermal shutdown latch
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			tsd_r <= 1'b0;
		else if (sd_off_s)
			tsd_r <= 1'b1;
		else if (srr_pulse_r && sd_on_s)
			tsd_r <= 1'b0;
	end

	// Sticky flags, a new event wins over the clear
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			scd_r <= 1'b0;
			psf_r <= 1'b0;
		end
		else
		begin
			if (|trip_evt)
				scd_r <= 1'b1;
			else if (srr_pulse_r)
				scd_r <= 1'b0;
			if (uv_s)
				psf_r <= 1'b1;
			else if (srr_pulse_r)
				psf_r <= 1'b0;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < DPSL_NUM_OUT; gi++)
		begin : g_out
			dpsl_short_timer #(
				.LONG_CNT  (LONG_CNT),
				.SHORT_CNT (SHORT_CNT)
			) u_tmr (
				.clock       (clock),
				.resetn      (resetn),
				.osc_tick    (osc_tick),
				.overcurrent (oc_s[gi] && out_enable[gi]),
				.prewarn     (tp_r),
				.long_sel    (cmd_r[DPSL_CMD_SCT]),
				.clear       (srr_pulse_r),
				.trip_evt    (trip_evt[gi]),
				.tripped_r   (tripped[gi])
			);
		end
	endgenerate

	assign inhibit    = !cmd_r[DPSL_CMD_SI] || !inh_s;
	assign out_en_nxt = cmd_r[DPSL_CMD_OUT_HI:DPSL_CMD_OUT_LO] & ~tripped & ~trip_evt &
		{DPSL_NUM_OUT{!tsd_r && !sd_off_s && !inhibit && !uv_s}};

	always_comb
	begin
		if (tsd_r)
			status_word = DPSL_ST_SHUTDOWN;
		else
			status_word = {psf_r, inhibit, scd_r, out_enable, tp_r};
	end

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			out_enable          <= 12'h000;
			temp_prewarn_flag   <= 1'b0;
			short_detected_flag <= 1'b0;
			supply_fail_flag    <= 1'b0;
			thermal_shutdown    <= 1'b0;
			standby             <= 1'b1;
		end
		else
		begin
			out_enable          <= out_en_nxt;
			temp_prewarn_flag   <= tp_r;
			short_detected_flag <= scd_r;
			supply_fail_flag    <= psf_r;
			thermal_shutdown    <= tsd_r;
			standby             <= inhibit;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);

	sequence s_cool_reset;
		srr_pulse_r && sd_on_s && !sd_off_s;
	endsequence

	sequence s_stay_hot;
		tsd_r && !(srr_pulse_r && sd_on_s);
	endsequence

	a_prewarn_set: assert property (
		pw_set_s |=> tp_r)
		else $error("prewarning flag not set");

	a_prewarn_reset: assert property (
		(pw_rst_s && !pw_set_s) |=> !tp_r ##1 !temp_prewarn_flag || pw_set_s)
		else $error("prewarning flag not cleared");

	a_quick_peek: assert property (
		(link_r == DPSL_IDLE && cs_fall) |=> sdo_oe && sdo == $past(status_word[DPSL_ST_TP]))
		else $error("prewarning not shown on chip select fall");

	a_abort_keeps: assert property (
		(link_r == DPSL_SHIFT && cs_rise && !word_ok) |=> $stable(cmd_r) && !srr_pulse_r)
		else $error("aborted frame changed the command word");

	a_shutdown_off: assert property (
		sd_off_s |=> tsd_r && status_word == DPSL_ST_SHUTDOWN ##1 out_enable == 12'h000)
		else $error("thermal shutdown did not force outputs off");

	a_shutdown_hold: assert property (
		s_stay_hot |=> tsd_r)
		else $error("shutdown released without cool die and status reset");

	a_shutdown_clear: assert property (
		(tsd_r ##0 s_cool_reset) |=> !tsd_r)
		else $error("shutdown not released by status reset");

	a_short_flag: assert property (
		(|trip_evt) |=> scd_r && (out_enable & $past(trip_evt)) == 12'h000)
		else $error("trip did not set flag and disable output");

	a_srr_clear: assert property (
		(srr_pulse_r && !(|trip_evt)) |=> !scd_r && tripped == 12'h000)
		else $error("status reset did not clear the short state");

	a_inhibit_off: assert property (
		inhibit |=> out_enable == 12'h000 && standby)
		else $error("inhibit did not turn outputs off");

	a_inhibit_bit: assert property (
		!tsd_r |-> status_word[DPSL_ST_INH] == (!cmd_r[DPSL_CMD_SI] || !inh_s))
		else $error("status inhibit bit wrong");

	a_srr_oneshot: assert property (
		srr_pulse_r |=> !srr_pulse_r && !cmd_r[DPSL_CMD_SRR])
		else $error("status reset held longer than one cycle");

endmodule : dpsl_top
`default_nettype wire

/* File: src/dpsl_unused_placeholder_removed.sv */
// Intentionally empty design unit list
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire
